// >>> logic/rxdp_cfg.svh
// constants of the receive drop-side packet/cell port
`ifndef RXDP_CFG_SVH
`define RXDP_CFG_SVH
`define RXDP_DATA_W      32
`define RXDP_FIFO_DEPTH  16
`define RXDP_CELL_WORDS  14
`define RXDP_LINK_HALF   4
`define RXDP_MOD_4BYTES  2'h0
`define RXDP_MOD_3BYTES  2'h1
`define RXDP_MOD_2BYTES  2'h2
`define RXDP_MOD_1BYTE   2'h3
`define RXDP_PKT_BIT_W   8
`endif

// >>> logic/rxdp_pkg.sv
// types shared by both ends of the receive packet/cell port
package rxdp_pkg;
  typedef struct packed {
    logic        start;
    logic        last;
    logic [1:0]  modulo;
    logic        error;
    logic [31:0] data;
  } rxdp_word_s;
  typedef enum logic {
    RXDP_PACKET_MODE,
    RXDP_CELL_MODE
  } rxdp_mode_e;
  function automatic logic rxdp_parity(input logic [31:0] data, input logic even);
    rxdp_parity = even ? (^data) : ~(^data);
  endfunction
endpackage

// >>> logic/rxdp_if.sv
// link between the framer receive port and the link layer
`timescale 1ns/1ps
`default_nettype none
interface rxdp_if;
  logic        rx_interface_clock;
  logic        rx_clock_looped_out;
  logic        rx_read_enable_n;
  logic [31:0] rx_packet_data_bus;
  logic        rx_packet_start;
  logic        rx_packet_end;
  logic [1:0]  rx_word_modulo;
  logic        rx_packet_error;
  logic        rx_bus_parity;
  logic        rx_valid_flag;
  modport phy (
    input  rx_interface_clock,
    input  rx_read_enable_n,
    output rx_clock_looped_out,
    output rx_packet_data_bus,
    output rx_packet_start,
    output rx_packet_end,
    output rx_word_modulo,
    output rx_packet_error,
    output rx_bus_parity,
    output rx_valid_flag
  );
  modport link (
    output rx_interface_clock,
    output rx_read_enable_n,
    input  rx_clock_looped_out,
    input  rx_packet_data_bus,
    input  rx_packet_start,
    input  rx_packet_end,
    input  rx_word_modulo,
    input  rx_packet_error,
    input  rx_bus_parity,
    input  rx_valid_flag
  );
endinterface // rxdp_if
`default_nettype wire

// >>> logic/rxdp_fifo.sv
// receive word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "rxdp_cfg.svh"
module rxdp_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = `RXDP_FIFO_DEPTH
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [WIDTH-1:0]       in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [WIDTH-1:0]            out_data,
  output logic [$clog2(DEPTH):0]      count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_size_check
    $error("rxdp_fifo: depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end
  // ready is registered so the port leaves straight from a flop
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // rxdp_fifo
`default_nettype wire

// >>> logic/rxdp_phy.sv
// framer end of the receive packet/cell port
// Notes on behaviour
// RULE_01: modulo marks valid bytes of the word
// RULE_02: packet start flag on first word
// RULE_03: packet end flag on last word
// RULE_04: link may ignore start; end suffices
// RULE_05: all qualifiers valid while valid high
// RULE_06: link discards everything while valid low
// RULE_07: valid drops on empty or after end
// RULE_08: no fifo removal while valid low
// RULE_09: valid stays low until link deselects
// RULE_10: error flag only on end word
// RULE_11: packet read enable announces next-edge sampling
// RULE_12: cell read enable announces next-edge sampling
// RULE_13: link supplies clock; transfers follow it
// RULE_14: supplied clock is looped back out
// RULE_15: cell start flag on first word
// RULE_16: flag is empty_n or cell available
// RULE_17: parity over 32 bits, odd default
// RULE_18: 32-bit word, bit 31 msb, aligned packets
// RULE_19: read enable high counts as deselect
// RULE_20: cell available needs one whole cell
`timescale 1ns/1ps
`default_nettype none
`include "rxdp_cfg.svh"
module rxdp_phy #(
  parameter int DEPTH      = `RXDP_FIFO_DEPTH,
  parameter int CELL_WORDS = `RXDP_CELL_WORDS
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  rxdp_if.phy                       link,
  input  wire rxdp_pkg::rxdp_mode_e mode,
  input  wire logic                 cell_level_flow,
  input  wire logic                 parity_even,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire rxdp_pkg::rxdp_word_s in_word
);
  localparam int CW = $clog2(DEPTH) + 1;
  if (CELL_WORDS < 1 || CELL_WORDS > DEPTH)
  begin : g_cell_check
    $error("rxdp_phy: cell must fit in the fifo");
  end
  if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH)
  begin : g_depth_check
    $error("rxdp_phy: fifo depth must be a power of two");
  end
  // non-end words always carry four bytes
  function automatic logic [1:0] shown_modulo(input rxdp_pkg::rxdp_word_s w);
    shown_modulo = w.last ? w.modulo : `RXDP_MOD_4BYTES;
  endfunction
  rxdp_pkg::rxdp_word_s       head;
  logic                       head_valid;
  logic                       pop;
  logic [CW-1:0]              count;
  logic                       clk_s1;
  logic                       clk_s2;
  logic                       clk_s3;
  logic                       ren_s1;
  logic                       ren_s2;
  logic                       link_edge;
  logic                       link_read;
  logic                       link_desel;
  logic                       blocked;
  logic                       next_blocked;
  logic                       next_valid;
  logic                       cell_mode;
  logic                       word_avail;
  logic                       cell_avail;
  rxdp_fifo #(
    .WIDTH ($bits(rxdp_pkg::rxdp_word_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head),
    .count     (count)
  );
  assign cell_mode  = (mode == rxdp_pkg::RXDP_CELL_MODE);
  assign link_edge  = clk_s2 && !clk_s3; // RULE_13
  assign link_read  = link_edge && !ren_s2; // RULE_11 RULE_12
  assign link_desel = link_edge && ren_s2; // RULE_19
  assign word_avail = head_valid;
  assign cell_avail = (count >= CW'(CELL_WORDS)); // RULE_20
  // in packet mode words leave the fifo only when presented with valid high; in cell mode any read pops a held word
  assign pop = link_read && head_valid && (cell_mode || !blocked); // RULE_08
  // link clock passes two flops before its edge is found
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end
    else
    begin
      clk_s1 <= link.rx_interface_clock;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end
  // read enable synchronised the same way as the clock
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ren_s1 <= 1'b1;
      ren_s2 <= 1'b1;
    end
    else
    begin
      ren_s1 <= link.rx_read_enable_n;
      ren_s2 <= ren_s1;
    end
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_clock_looped_out <= 1'b0;
    else
      link.rx_clock_looped_out <= clk_s2; // RULE_14
  end
  // data and qualifiers change only on a read-enabled link edge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_packet_data_bus <= '0;
    else if (pop)
      link.rx_packet_data_bus <= head.data; // RULE_18
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_packet_start <= 1'b0;
    else if (pop)
      link.rx_packet_start <= head.start; // RULE_02 RULE_15
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_packet_end <= 1'b0;
    else if (pop)
      link.rx_packet_end <= head.last && !cell_mode; // RULE_03
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_word_modulo <= `RXDP_MOD_4BYTES;
    else if (pop)
      link.rx_word_modulo <= shown_modulo(head); // RULE_01
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_packet_error <= 1'b0;
    else if (pop)
      link.rx_packet_error <= head.last && head.error && !cell_mode; // RULE_10
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_bus_parity <= 1'b0;
    else if (pop)
      link.rx_bus_parity <= rxdp_pkg::rxdp_parity(head.data, parity_even); // RULE_17
  end
  // packet-mode lockout after valid falls
  always_comb
  begin
    next_blocked = blocked;
    if (link_desel)
      next_blocked = 1'b0; // RULE_09 RULE_19
    else if (link_read)
    begin
      if (!blocked && head_valid)
        next_blocked = head.last; // RULE_07
      else
        next_blocked = 1'b1; // RULE_07 RULE_09
    end
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      blocked <= 1'b0;
    else
      blocked <= next_blocked;
  end
  // shared flag: valid in packet mode, empty_n or cell available in cell mode
  always_comb
  begin
    next_valid = link.rx_valid_flag;
    if (cell_mode)
    begin
      if (cell_level_flow)
        next_valid = cell_avail; // RULE_16 RULE_20
      else
        next_valid = word_avail; // RULE_16
    end
    else if (link_read)
      next_valid = pop; // RULE_05 RULE_07 RULE_08
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_valid_flag <= 1'b0;
    else
      link.rx_valid_flag <= next_valid;
  end
endmodule // rxdp_phy
`default_nettype wire

// >>> logic/rxdp_link.sv
// link-layer end of the receive packet/cell port
`timescale 1ns/1ps
`default_nettype none
`include "rxdp_cfg.svh"
module rxdp_link #(
  parameter int LINK_HALF = `RXDP_LINK_HALF
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  rxdp_if.link                      link,
  input  wire rxdp_pkg::rxdp_mode_e mode,
  input  wire logic                 parity_even,
  input  wire logic                 out_ready,
  output logic                      out_valid,
  output rxdp_pkg::rxdp_word_s      out_word,
  output logic                      out_parity_error
);
  if (LINK_HALF < 4 || LINK_HALF > 255)
  begin : g_half_check
    $error("rxdp_link: link half period must be 4 to 255 cycles");
  end
  localparam int SW = 39;
  logic [7:0]    div_cnt;
  logic          rise;
  logic [SW-1:0] in_s1;
  logic [SW-1:0] in_s2;
  logic [SW-1:0] in_raw;
  logic          flag;
  logic          cell_mode;
  assign in_raw    = {link.rx_valid_flag, link.rx_bus_parity, link.rx_packet_start, link.rx_packet_end,
                      link.rx_word_modulo, link.rx_packet_error, link.rx_packet_data_bus};
  assign flag      = in_s2[38];
  assign cell_mode = (mode == rxdp_pkg::RXDP_CELL_MODE);
  assign rise      = (div_cnt == 8'(LINK_HALF - 1)) && !link.rx_interface_clock;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_s1 <= '0;
      in_s2 <= '0;
    end
    else
    begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
    end
  end
  // link clock made by dividing the local clock
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt                 <= '0;
      link.rx_interface_clock <= 1'b0;
    end
    else if (div_cnt == 8'(LINK_HALF - 1))
    begin
      div_cnt                 <= '0;
      link.rx_interface_clock <= !link.rx_interface_clock; // RULE_13
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end
  // read enable changes only with the rising link edge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      link.rx_read_enable_n <= 1'b1;
    else if (rise)
    begin
      if (cell_mode)
        link.rx_read_enable_n <= !(out_ready && flag && link.rx_read_enable_n); // RULE_12
      else
        link.rx_read_enable_n <= !(out_ready && !(!link.rx_read_enable_n && !flag)); // RULE_11 RULE_19
    end
  end
  // take a word at the edge after an enabled one
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_valid        <= 1'b0;
      out_word         <= '0;
      out_parity_error <= 1'b0;
    end
    else
    begin
      out_valid <= rise && !link.rx_read_enable_n && (cell_mode || flag); // RULE_06
      if (rise && !link.rx_read_enable_n)
      begin
        out_word.data    <= in_s2[31:0];
        out_word.error   <= in_s2[32] && in_s2[35]; // RULE_10
        out_word.modulo  <= in_s2[34:33]; // RULE_01
        out_word.last    <= in_s2[35]; // RULE_04
        out_word.start   <= in_s2[36];
        out_parity_error <= in_s2[37] != rxdp_pkg::rxdp_parity(in_s2[31:0], parity_even); // RULE_17
      end
    end
  end
endmodule // rxdp_link
`default_nettype wire

// >>> verif/rxdp_link_assertions.sv
// concurrent checks on the receive port interface
`timescale 1ns/1ps
`default_nettype none
module rxdp_link_assertions (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire rxdp_pkg::rxdp_mode_e mode,
  input wire logic                 parity_even,
  input wire logic                 rx_interface_clock,
  input wire logic                 rx_clock_looped_out,
  input wire logic                 rx_read_enable_n,
  input wire logic [31:0]          rx_packet_data_bus,
  input wire logic                 rx_packet_end,
  input wire logic                 rx_packet_error,
  input wire logic                 rx_bus_parity,
  input wire logic                 rx_valid_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic       pkt;
  logic [7:0] since_rise;
  logic [7:0] since_desel;
  assign pkt = (mode == rxdp_pkg::RXDP_PACKET_MODE);
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) since_rise <= 8'hff;
    else if ($rose(rx_interface_clock)) since_rise <= 8'h00;
    else if (since_rise != 8'hff) since_rise <= since_rise + 8'h01;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) since_desel <= 8'h00;
    else if (rx_read_enable_n) since_desel <= 8'h00;
    else if (since_desel != 8'hff) since_desel <= since_desel + 8'h01;
  sequence s_end_word;
    pkt && rx_valid_flag && rx_packet_end;
  endsequence
  sequence s_high_half;
    rx_interface_clock [*4] ##1 !rx_interface_clock;
  endsequence
  a_error_on_end: assert property (pkt && rx_valid_flag && rx_packet_error |-> rx_packet_end)
    else $error("error flag away from end word");
  a_parity_sense: assert property (pkt && rx_valid_flag |->
    rx_bus_parity == (parity_even ? ^rx_packet_data_bus : ~^rx_packet_data_bus))
    else $error("bus parity wrong");
  a_end_drops: assert property (s_end_word ##1 !(rx_valid_flag && rx_packet_end) |-> !rx_valid_flag)
    else $error("valid kept after end word");
  a_relock_wait: assert property (pkt && $rose(rx_valid_flag) |-> since_desel < 8'h18)
    else $error("valid raised without deselect");
  a_valid_moves: assert property (pkt && $changed({rx_valid_flag, rx_packet_data_bus}) |->
    since_rise >= 8'h01 && since_rise <= 8'h06)
    else $error("bus changed away from link edge");
  a_loop_follow: assert property ($rose(rx_interface_clock) |-> ##[1:4] $rose(rx_clock_looped_out))
    else $error("looped clock missing");
  a_enable_sync: assert property ($changed(rx_read_enable_n) |-> rx_interface_clock)
    else $error("enable moved off link edge");
  a_half_period: assert property ($rose(rx_interface_clock) |-> s_high_half)
    else $error("link clock half period wrong");
  a_cell_no_end: assert property (!pkt |-> !rx_packet_end && !rx_packet_error)
    else $error("end flag in cell mode");
endmodule // rxdp_link_assertions
`default_nettype wire

// >>> verif/rx_drop_side_packet_cell_port_test.sv
// self-checking bench joining both ends of the receive port
`timescale 1ns/1ps
`default_nettype none
module rx_drop_side_packet_cell_port_test;
  logic                 clock;
  logic                 sys_rst;
  rxdp_pkg::rxdp_mode_e mode;
  logic                 cell_level_flow;
  logic                 parity_even;
  logic                 in_valid;
  logic                 in_ready;
  rxdp_pkg::rxdp_word_s in_word;
  logic                 out_ready;
  logic                 out_valid;
  rxdp_pkg::rxdp_word_s out_word;
  logic                 out_parity_error;
  rxdp_pkg::rxdp_word_s exp_q[$];
  rxdp_pkg::rxdp_word_s got_q[$];
  int                   n_fail;
  int                   check_count;
  logic [23:0]          dnum;
  bit                   ok;
  rxdp_if lnk ();
  rxdp_phy i_rxdp_phy (.clock(clock), .sys_rst(sys_rst), .link(lnk.phy), .mode(mode),
    .cell_level_flow(cell_level_flow), .parity_even(parity_even), .in_valid(in_valid),
    .in_ready(in_ready), .in_word(in_word));
  rxdp_link #(.LINK_HALF(4)) i_rxdp_link (.clock(clock), .sys_rst(sys_rst), .link(lnk.link), .mode(mode),
    .parity_even(parity_even), .out_ready(out_ready), .out_valid(out_valid), .out_word(out_word),
    .out_parity_error(out_parity_error));
  rxdp_link_assertions i_rxdp_link_assertions (.clock(clock), .sys_rst(sys_rst), .mode(mode),
    .parity_even(parity_even), .rx_interface_clock(lnk.rx_interface_clock),
    .rx_clock_looped_out(lnk.rx_clock_looped_out), .rx_read_enable_n(lnk.rx_read_enable_n),
    .rx_packet_data_bus(lnk.rx_packet_data_bus), .rx_packet_end(lnk.rx_packet_end),
    .rx_packet_error(lnk.rx_packet_error), .rx_bus_parity(lnk.rx_bus_parity), .rx_valid_flag(lnk.rx_valid_flag));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_word(input rxdp_pkg::rxdp_word_s got, input rxdp_pkg::rxdp_word_s exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // capture every word handed out by the link end
  always @(negedge clock)
    if (out_valid === 1'b1)
    begin
      got_q.push_back(out_word);
      cmp_bit(out_parity_error, 1'b0);
    end
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    got_q.delete();
  endtask
  task automatic push(input logic st, input logic ls, input logic [1:0] md, input logic er, input int tries);
    rxdp_pkg::rxdp_word_s w;
    w = '{st, ls, md, er, {8'h9e, dnum}};
    ok = 1'b0;
    @(posedge clock);
    #1;
    in_word = w;
    in_valid = 1'b1;
    for (int i = 0; i < tries && !ok; i++)
    begin
      ok = (in_ready === 1'b1);
      @(posedge clock);
      #1;
    end
    in_valid = 1'b0;
    if (ok)
    begin
      dnum = dnum + 24'h00_0001;
      if (mode == rxdp_pkg::RXDP_CELL_MODE) w = '{st, 1'b0, 2'h0, 1'b0, w.data};
      exp_q.push_back(w);
    end
  endtask
  task automatic send(input int n, input logic [1:0] md, input logic er);
    for (int i = 0; i < n; i++)
    begin
      push(i == 0, i == n - 1, (i == n - 1) ? md : 2'h0, (i == n - 1) && er, 400);
      if (!ok)
      begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  task automatic drain();
    rxdp_pkg::rxdp_word_s g;
    for (int i = 0; i < 4000 && got_q.size() < exp_q.size(); i++)
      @(posedge clock);
    if (got_q.size() != exp_q.size())
    begin
      n_fail++;
      tally_and_finish();
    end
    while (exp_q.size() > 0)
    begin
      g = got_q.pop_front();
      if (mode == rxdp_pkg::RXDP_CELL_MODE) g.modulo = 2'h0;
      cmp_word(g, exp_q.pop_front());
    end
    repeat (40) @(posedge clock);
    #1;
    cmp_bit(got_q.size() == 0, 1'b1);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    mode = rxdp_pkg::RXDP_PACKET_MODE;
    cell_level_flow = 1'b0;
    parity_even = 1'b0;
    in_valid = 1'b0;
    in_word = '0;
    out_ready = 1'b1;
    n_fail = 0;
    check_count = 0;
    dnum = 24'h00_0000;
    do_reset();
    send(3, 2'h1, 1'b0);
    send(1, 2'h3, 1'b1);
    send(2, 2'h2, 1'b0);
    drain();
    out_ready = 1'b0;
    repeat (40) @(posedge clock);
    send(16, 2'h0, 1'b0);
    push(1'b0, 1'b0, 2'h0, 1'b0, 3);
    cmp_bit(ok, 1'b0);
    out_ready = 1'b1;
    drain();
    parity_even = 1'b1;
    do_reset();
    send(2, 2'h0, 1'b1);
    drain();
    mode = rxdp_pkg::RXDP_CELL_MODE;
    cell_level_flow = 1'b1;
    do_reset();
    send(13, 2'h0, 1'b0);
    repeat (200) @(posedge clock);
    cmp_bit(got_q.size() == 0, 1'b1);
    push(1'b0, 1'b0, 2'h0, 1'b0, 400);
    repeat (100) @(posedge clock);
    #1;
    cmp_bit(got_q.size() != 0, 1'b1);
    cell_level_flow = 1'b0;
    drain();
    tally_and_finish();
  end
endmodule // rx_drop_side_packet_cell_port_test
`default_nettype wire
